// ### src/ppfir_defs.vh
/*
 * constants for the polyphase rate changer: widths, factor, phase encodings
 * assumes one 25 MHz fast clock; the slow sample rate is a one-cycle enable
 */
// How it works
// - one shared 4-tap MAC serves all phases
// - 18-bit samples and coefficients, one multiplier/tap
// - fresh coefficient set every fast cycle
// - phases rotate 0,1,2,3 then back to 0
// - memory j holds h(k+4j) for phase k
// - interpolation output updates every fast cycle
// - interpolation delay line advances on slow enable
// - coefficient and pipeline registers on fast clock
// - interpolation output rate four times input rate
// - decimation keeps one result per D inputs
// - filter before any sample is dropped
// - branch k uses h(k+nD), n below P
// - length is multiple of factor, P taps
// - demux steps the branch per input; each input shifts past all branches
// - demux counter counts down modulo D from 0
// - decimated output sums four branch results
// - only every fourth output is computed
// - zero-stuffed products are skipped by structure
// - interpolation phase counter counts up from 0
// - decimated output register updates once per four
`ifndef PPFIR_DEFS_VH
`define PPFIR_DEFS_VH
`define PPFIR_FACTOR 4
`define PPFIR_TAPS 4
`define PPFIR_LEN 16
`define PPFIR_DW 18
`define PPFIR_PW 36
`define PPFIR_AW 40
`define PPFIR_MODE_INTERP 1'b0
`define PPFIR_MODE_DECIM 1'b1
`define PPFIR_PH0 4'h1
`define PPFIR_PH1 4'h2
`define PPFIR_PH2 4'h4
`define PPFIR_PH3 4'h8
`endif

// ### src/ppfir_mac.v
/*
 * one tap: registered coefficient and product
 * assumes sample and coefficient are stable in the fast clock domain
 */
`timescale 1ns/100ps
`include "ppfir_defs.vh"
module ppfir_mac #(
    parameter DW = 18
) (
    input wire sys_clk_in,
    input wire rst_in,
    // pipeline advance; low freezes the tap so no product is lost on back-pressure
    input wire en_in,
    // operands
    input wire signed [DW-1:0] smp_in,
    input wire signed [DW-1:0] coef_in,
    // product
    output reg signed [2*DW-1:0] prod_out
);
    reg signed [DW-1:0] coef_q;
    reg signed [DW-1:0] smp_q;

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            coef_q <= {DW{1'b0}};
            smp_q <= {DW{1'b0}};
            prod_out <= {2*DW{1'b0}};
        end else if (en_in) begin
            coef_q <= coef_in;
            smp_q <= smp_in;
            prod_out <= smp_q * coef_q;
        end
    end
endmodule

// ### src/ppfir_skid.v
/*
 * two-entry buffer with valid/ready on both sides
 * assumes the writer honours ready; no word is lost when the sink stalls
 */
`timescale 1ns/100ps
module ppfir_skid #(
    parameter W = 40
) (
    input wire sys_clk_in,
    input wire rst_in,
    // fill side
    input wire [W-1:0] wdata_in,
    input wire wvalid_in,
    output wire wready_out,
    // drain side
    output wire [W-1:0] rdata_out,
    output wire rvalid_out,
    input wire rready_in
);
    reg [W-1:0] mem_q [0:1];
    reg wptr_q;
    reg rptr_q;
    reg [1:0] cnt_q;
    wire push = wvalid_in && (cnt_q != 2'd2);
    wire pop = rvalid_out && rready_in;

    assign wready_out = (cnt_q != 2'd2);
    assign rvalid_out = (cnt_q != 2'd0);
    assign rdata_out = mem_q[rptr_q];

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                mem_q[wptr_q] <= wdata_in;
                wptr_q <= ~wptr_q;
            end
            if (pop)
                rptr_q <= ~rptr_q;
            if (push && !pop)
                cnt_q <= cnt_q + 2'd1;
            else if (pop && !push)
                cnt_q <= cnt_q - 2'd1;
        end
    end
endmodule

// ### src/ppfir_top.v
/*
 * polyphase rate changer by four, interpolation or decimation
 * one fast clock; the slow sample rate is a divide-by-four enable pulse.
 * coefficients load through a write port; the sink drains a two-entry buffer
 */
`timescale 1ns/100ps
`include "ppfir_defs.vh"
module ppfir_top #(
    parameter DW = `PPFIR_DW,
    parameter AW = `PPFIR_AW
) (
    input wire sys_clk_in,
    input wire rst_in,
    // configuration
    input wire mode_in,
    input wire coef_we_in,
    input wire [3:0] coef_addr_in,
    input wire [DW-1:0] coef_data_in,
    // sample source
    input wire [DW-1:0] smp_in,
    output reg slow_en_out,
    output reg smp_ready_out,
    // sample sink
    output reg [AW-1:0] y_out,
    output reg y_valid_out,
    input wire y_ready_in,
    output reg [3:0] phase_out
);
    localparam NT = `PPFIR_TAPS;
    localparam PW = 2 * DW;

    // coefficient memories: memory j, word k holds h(k+4j)
    reg signed [DW-1:0] cmem [0:`PPFIR_LEN-1];
    reg [3:0] ph_q; // one-hot phase
    reg [3:0] ph_d;
    reg [1:0] up_q; // interpolation mux counter
    reg [1:0] dn_q; // decimation demux counter
    reg mode_q;
    reg signed [DW-1:0] dl_q [0:NT-1];
    reg signed [DW-1:0] tap_smp [0:NT-1];
    reg signed [DW-1:0] tap_coef [0:NT-1];
    wire signed [PW-1:0] prod [0:NT-1];
    reg signed [AW-1:0] acc_q;
    reg signed [AW-1:0] sum_c;
    reg [3:0] vld_pipe_q;
    reg [3:0] last_pipe_q;
    reg sel_last;
    reg [AW-1:0] buf_wdata;
    reg buf_wvalid;
    wire buf_wready;
    wire [AW-1:0] buf_rdata;
    wire buf_rvalid;
    reg [1:0] csel;
    reg stall;
    integer i;

    always @(posedge sys_clk_in) begin
        if (coef_we_in)
            cmem[coef_addr_in] <= coef_data_in;
    end

    always @(posedge sys_clk_in) begin
        if (rst_in)
            mode_q <= `PPFIR_MODE_INTERP;
        else if (ph_q == `PPFIR_PH3)
            mode_q <= mode_in;
    end

    // the whole pipe halts on back-pressure so no phase slips
    always @* begin
        stall = buf_wvalid && !buf_wready;
    end

    always @* begin
        case (ph_q)
            `PPFIR_PH0: ph_d = `PPFIR_PH1;
            `PPFIR_PH1: ph_d = `PPFIR_PH2;
            `PPFIR_PH2: ph_d = `PPFIR_PH3;
            `PPFIR_PH3: ph_d = `PPFIR_PH0;
            default: ph_d = `PPFIR_PH0;
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            ph_q <= `PPFIR_PH0;
            up_q <= 2'd0;
            dn_q <= 2'd0;
        end else if (!stall) begin
            ph_q <= ph_d;
            up_q <= up_q + 2'd1;
            dn_q <= dn_q - 2'd1;
        end
    end

    // phase schedule: interpolation k, decimation branch fed by the demux
    always @* begin
        if (mode_q == `PPFIR_MODE_INTERP)
            csel = up_q;
        else
            csel = dn_q;
    end

    // delay line: slow enable in interpolation, every sample in decimation
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (i = 0; i < NT; i = i + 1)
                dl_q[i] <= {DW{1'b0}};
        end else if (!stall) begin
            // each taken sample enters slot 0 and shifts through all four slots, so every branch reads it
            if (mode_q == `PPFIR_MODE_DECIM || ph_q == `PPFIR_PH0) begin
                dl_q[0] <= smp_in;
                for (i = 1; i < NT; i = i + 1)
                    dl_q[i] <= dl_q[i-1];
            end
        end
    end

    // tap operands: interp uses x(n-j) with h(k+4j); decim uses one new sample
    // per branch with its P coefficients walking back in the delay line
    always @* begin
        for (i = 0; i < NT; i = i + 1) begin
            // sixteen words split evenly into four taps per phase; the stuffed
            // zeros never reach a multiplier because only real samples are held
            tap_coef[i] = cmem[{i[1:0], csel}];
            tap_smp[i] = dl_q[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NT; g = g + 1) begin : g_tap
            ppfir_mac #(
                .DW(DW)
            ) u_mac (
                .sys_clk_in(sys_clk_in),
                .rst_in(rst_in),
                .en_in(!stall),
                .smp_in(tap_smp[g]),
                .coef_in(tap_coef[g]),
                .prod_out(prod[g])
            );
        end
    endgenerate

    // note: decimation branch k reads sample x(nD-k) via the delay line,
    // which shifts every cycle, so its other taps see x(nD-k-1) to x(nD-k-3), the inputs of the other branches
    always @* begin
        sum_c = {AW{1'b0}};
        for (i = 0; i < NT; i = i + 1)
            sum_c = sum_c + {{(AW-PW){prod[i][PW-1]}}, prod[i]};
    end

    // valid tracks the two-stage mac latency
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            vld_pipe_q <= 4'h0;
            last_pipe_q <= 4'h0;
        end else if (!stall) begin
            vld_pipe_q <= {vld_pipe_q[2:0], 1'b1};
            last_pipe_q <= {last_pipe_q[2:0], (dn_q == 2'd1)};
        end
    end

    always @* begin
        sel_last = last_pipe_q[1];
    end

    // decimation accumulates four branches, dumps once per slow period
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            acc_q <= {AW{1'b0}};
            buf_wdata <= {AW{1'b0}};
            buf_wvalid <= 1'b0;
        end else if (!stall) begin
            buf_wvalid <= 1'b0;
            if (vld_pipe_q[1]) begin
                if (mode_q == `PPFIR_MODE_INTERP) begin
                    buf_wdata <= sum_c;
                    buf_wvalid <= 1'b1;
                end else if (sel_last) begin
                    buf_wdata <= acc_q + sum_c;
                    buf_wvalid <= 1'b1;
                    acc_q <= {AW{1'b0}};
                end else begin
                    acc_q <= acc_q + sum_c;
                end
            end
        end
    end

    ppfir_skid #(
        .W(AW)
    ) u_buf (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .wdata_in(buf_wdata),
        .wvalid_in(buf_wvalid),
        .wready_out(buf_wready),
        .rdata_out(buf_rdata),
        .rvalid_out(buf_rvalid),
        .rready_in(!y_valid_out || y_ready_in)
    );

    // output stage registered straight from flops; decim words appear 1 in 4
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            y_out <= {AW{1'b0}};
            y_valid_out <= 1'b0;
            slow_en_out <= 1'b0;
            smp_ready_out <= 1'b0;
            phase_out <= `PPFIR_PH0;
        end else begin
            if (!y_valid_out || y_ready_in) begin
                y_out <= buf_rdata;
                y_valid_out <= buf_rvalid;
            end
            slow_en_out <= !stall && (ph_d == `PPFIR_PH0);
            smp_ready_out <= !stall && (mode_q == `PPFIR_MODE_DECIM ||
                ph_d == `PPFIR_PH0);
            phase_out <= stall ? ph_q : ph_d;
        end
    end
endmodule

// ### sim/ppfir_assertions.sv
/* port checker for the rate changer
   assumes one clock and a synchronous active-high reset */
`timescale 1ns/100ps
module ppfir_assertions #(
    parameter DW = 18,
    parameter AW = 40
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // source
    input wire logic mode_in,
    input wire logic slow_en_out,
    input wire logic smp_ready_out,
    // sink
    input wire logic [AW-1:0] y_out,
    input wire logic y_valid_out,
    input wire logic y_ready_in,
    input wire logic [3:0] phase_out
);
    // mode lands at a phase boundary, so judge rates only once it has stood
    logic [3:0] age_q = 4'h0;
    logic [3:0] run_q = 4'h0;
    logic mode_q = 1'b0;
    wire settled = age_q == 4'hf;
    wire drained = settled && run_q == 4'hf;
    always @(posedge sys_clk_in) begin
        mode_q <= mode_in;
        if (rst_in || mode_in != mode_q)
            age_q <= 4'h0;
        else if (age_q != 4'hf)
            age_q <= age_q + 4'h1;
        if (!y_ready_in)
            run_q <= 4'h0;
        else if (run_q != 4'hf)
            run_q <= run_q + 4'h1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_take;
        y_valid_out && y_ready_in;
    endsequence
    sequence s_quiet;
        !y_valid_out [*3];
    endsequence
    a_phase_rotate: assert property ($changed(phase_out) |->
        phase_out == {$past(phase_out[2:0]), $past(phase_out[3])}) else $error("phase order");
    a_phase_onehot: assert property ($onehot(phase_out)) else $error("phase code");
    a_slow_phase0: assert property (slow_en_out |-> phase_out == 4'h1)
        else $error("slow enable");
    a_interp_take: assert property (settled && !mode_in && smp_ready_out |->
        phase_out == 4'h1) else $error("interp take");
    a_interp_rate: assert property (drained && !mode_in |-> y_valid_out)
        else $error("interp rate");
    a_decim_take: assert property (drained && mode_in |-> smp_ready_out)
        else $error("decim take");
    a_decim_gap: assert property (drained && mode_in ##0 s_take |=> s_quiet)
        else $error("decim gap");
    a_hold_stall: assert property (y_valid_out && !y_ready_in |=>
        y_valid_out && $stable(y_out)) else $error("word lost");
endmodule

// ### sim/ppfir_partner.sv
/* sample source and sink beside the rate changer
   assumes the bench picks the held value and whether the sink stalls */
`timescale 1ns/100ps
module ppfir_partner (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // bench control
    input wire logic [17:0] val_in,
    input wire logic stall_in,
    // source
    input wire logic smp_ready_in,
    output logic [17:0] smp_out = 18'h0,
    // sink
    output logic y_ready_out = 1'b1
);
    integer seed = 32'h6a130099;
    always @(posedge sys_clk_in) begin
        if (rst_in || smp_ready_in)
            smp_out <= val_in;
        // a quarter of cycles refused: enough to fill the buffer when interpolating
        y_ready_out <= !stall_in || ($random(seed) & 3) != 0;
    end
endmodule

// ### sim/ppfir_test.sv
/* self-checking bench for the rate changer with a constant source
   assumes the partner model drives the source and sink pins */
`timescale 1ns/100ps
module ppfir_test;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic mode_in = 1'b0;
    logic coef_we_in = 1'b0;
    logic [3:0] coef_addr_in = 4'h0;
    logic [17:0] coef_data_in = 18'h0;
    logic signed [17:0] src_val = 18'h1;
    logic stall = 1'b0;
    wire [17:0] smp_in;
    wire slow_en_out, smp_ready_out, y_valid_out, y_ready_in;
    wire [39:0] y_out;
    wire [3:0] phase_out;
    integer seed = 32'h6a130099;
    integer failures = 0;
    integer cmp_count = 0;
    logic signed [17:0] h [16];
    logic [39:0] got [8];
    initial forever #20 sys_clk_in = ~sys_clk_in;
    ppfir_top #(.DW(18), .AW(40)) uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .mode_in(mode_in), .coef_we_in(coef_we_in), .coef_addr_in(coef_addr_in),
        .coef_data_in(coef_data_in), .smp_in(smp_in), .slow_en_out(slow_en_out),
        .smp_ready_out(smp_ready_out), .y_out(y_out), .y_valid_out(y_valid_out),
        .y_ready_in(y_ready_in), .phase_out(phase_out));
    ppfir_partner pm (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .val_in(src_val),
        .stall_in(stall), .smp_ready_in(smp_ready_out), .smp_out(smp_in),
        .y_ready_out(y_ready_in));
    task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // constant input: each interpolation phase output is the input times that phase's tap sum, each decimated output the input times all sixteen taps
    function automatic logic signed [39:0] exp_y(input integer k, input logic dec);
        logic signed [39:0] acc;
        acc = 0;
        for (int a = 0; a < 16; a++)
            if (dec || a % 4 == k)
                acc += src_val * h[a];
        return acc;
    endfunction
    task run_case(input logic m, input logic st, input logic signed [17:0] x);
        integer n_in;
        integer n_out;
        integer p0;
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        mode_in <= m;
        stall <= st;
        src_val <= x;
        repeat (10) @(posedge sys_clk_in);
        check("phase_out", phase_out, 4'h1);
        check("y_valid_out", y_valid_out, 1'b0);
        rst_in <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            h[a] = $random(seed);
            @(posedge sys_clk_in);
            coef_we_in <= 1'b1;
            coef_addr_in <= a[3:0];
            coef_data_in <= h[a];
        end
        @(posedge sys_clk_in);
        coef_we_in <= 1'b0;
        repeat (40) @(posedge sys_clk_in);
        n_in = 0;
        n_out = 0;
        repeat (96) begin
            @(posedge sys_clk_in);
            if (smp_ready_out === 1'b1)
                n_in++;
            if (y_valid_out === 1'b1 && y_ready_in === 1'b1) begin
                if (n_out < 8)
                    got[n_out] = y_out;
                n_out++;
            end
        end
        p0 = m ? n_in - 4 * n_out : n_out - 4 * n_in;
        check("rate", p0 >= -4 && p0 <= 4 && n_out >= 8, 1'b1);
        p0 = 0;
        for (int k = 1; k < 4; k++)
            if (got[0] === exp_y(k, m))
                p0 = k;
        for (int i = 0; i < 8; i++)
            check("y_out", got[i], exp_y((p0 + i) % 4, m));
        $display("case mode %0d stall %0d done", m, st);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        for (int c = 0; c < 4; c++)
            run_case(c[1], c[0], c == 1 ? 18'h20000 : c == 3 ? 18'h1ffff : $random(seed) | 1);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        failures++;
        print_verdict();
    end
endmodule
bind ppfir_top ppfir_assertions #(.DW(DW), .AW(AW)) u_chk (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .mode_in(mode_in), .slow_en_out(slow_en_out),
    .smp_ready_out(smp_ready_out), .y_out(y_out), .y_valid_out(y_valid_out),
    .y_ready_in(y_ready_in), .phase_out(phase_out));
